// ### verilog/afi_pkg.sv
// Constants for the analog fault interrupt register block.
// Assumes a 32-bit APB slave with byte addresses, one word per register.
package afi_pkg;
    localparam int AW = 8;
    localparam int DW = 32;

    // Register byte offsets
    localparam logic [AW-1:0] OFS_SUP_STATUS = 8'h1C;
    localparam logic [AW-1:0] OFS_SUP_EN     = 8'h20;
    localparam logic [AW-1:0] OFS_SUP_CLR    = 8'h24;
    localparam logic [AW-1:0] OFS_SYS_EN     = 8'h28;
    localparam logic [AW-1:0] OFS_BR_EN      = 8'h5C;

    // Supply layout: 4 overvoltage bits above 4 undervoltage bits
    localparam int SUP_N   = 4;
    localparam int SUP_W   = 8;
    localparam int STS_LSB = 16;
    localparam int IS_LSB  = 0;
    localparam int OV_LSB  = 4;
    localparam int SUP_CORE = 3;
    localparam int SUP_BAT  = 0;

    localparam int SYS_W = 16;
    localparam int BR_W  = 21;

    localparam logic [SUP_W-1:0] SUP_EN_RST  = 8'hFF;
    localparam logic [SYS_W-1:0] SYS_EN_MASK = 16'hFFC7;
    localparam logic [SYS_W-1:0] SYS_EN_RST  = 16'h0000;
    localparam logic [BR_W-1:0]  BR_EN_MASK  = 21'h1F3C0F;
    localparam logic [BR_W-1:0]  BR_EN_RST   = 21'h000000;

    // Bit positions used by checks
    localparam int SYS_OT_BIT    = 9;
    localparam int SYS_RSVD_LSB  = 3;
    localparam int SYS_RSVD_MSB  = 5;
    localparam int BR_HS2_OC_BIT = 13;
    localparam int BR_LS1_DS_BIT = 0;
endpackage : afi_pkg

// ### verilog/afi_flag_if.sv
// Carrier between the register top and a sticky flag bank.
// Assumes det and clr are driven by the top in the REF_CLK domain.
`timescale 1ns/1ps
`default_nettype none
interface afi_flag_if #(
    parameter int W = 8
);
    logic [W-1:0] det;
    logic [W-1:0] clr;
    logic [W-1:0] flags;

    modport bank (input det, input clr, output flags);
    modport user (output det, output clr, input flags);
endinterface : afi_flag_if
`default_nettype wire

// ### verilog/afi_flag_bank.sv
// Sticky flag bank: level or rising-edge set, write-one clear.
// Assumes det is synchronous to clk; set beats clear in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module afi_flag_bank #(
    parameter int W    = 8,
    parameter bit EDGE = 1'b0
) (
    input  wire logic  clk,
    input  wire logic  rst,
    afi_flag_if.bank   f
);
    logic [W-1:0] prev_ff;
    logic [W-1:0] nxt_prev;
    logic [W-1:0] flags_ff;
    logic [W-1:0] nxt_flags;
    logic [W-1:0] set_v;

    always_comb begin
        nxt_prev  = f.det;
        // Edge mode raises one request per detection, not one per cycle
        set_v     = EDGE ? (f.det & ~prev_ff) : f.det;
        nxt_flags = (flags_ff & ~f.clr) | set_v;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_ff  <= '0;
            flags_ff <= '0;
        end else begin
            prev_ff  <= nxt_prev;
            flags_ff <= nxt_flags;
        end
    end

    assign f.flags = flags_ff;

    a_set_wins: assert property (@(posedge clk) disable iff (rst)
        1 |=> (($past(set_v) & ~f.flags) == '0))
        else $error("Flag set lost");
    a_hold_else: assert property (@(posedge clk) disable iff (rst)
        1 |=> (((f.flags ^ $past(f.flags)) & ~($past(set_v) | $past(f.clr))) == '0))
        else $error("Flag changed without cause");
    a_edge_only: assert property (@(posedge clk) disable iff (rst)
        EDGE |=> ((f.flags & ~$past(f.flags) & $past(prev_ff)) == '0))
        else $error("Flag set without rising edge");
endmodule : afi_flag_bank
`default_nettype wire

// ### verilog/afi_top.sv
// Analog fault interrupt registers: supply flags, enables, APB slave.
// Assumes APB master and event inputs synchronous to REF_CLK.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module afi_top #(
    parameter int AW = afi_pkg::AW
) (
    input  wire logic                      REF_CLK,
    input  wire logic                      SRST,
    input  wire logic                      RST3,
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [AW-1:0]             PADDR,
    input  wire logic [afi_pkg::DW-1:0]    PWDATA,
    output logic      [afi_pkg::DW-1:0]    PRDATA,
    output logic                           PREADY,
    output logic                           PSLVERR,
    input  wire logic [afi_pkg::SUP_N-1:0] SUPPLY_OV_DET,
    input  wire logic [afi_pkg::SUP_N-1:0] SUPPLY_UV_DET,
    input  wire logic [afi_pkg::SYS_W-1:0] SYS_IRQ_FLAGS,
    input  wire logic [afi_pkg::BR_W-1:0]  BRIDGE_IRQ_FLAGS,
    output logic                           IRQ
);
    logic                         apb_setup;
    logic                         apb_wr;
    logic                         hit_sts;
    logic                         hit_sup_en;
    logic                         hit_clr;
    logic                         hit_sys;
    logic                         hit_br;
    logic                         hit_any;
    logic [afi_pkg::SUP_W-1:0]    sup_en_ff;
    logic [afi_pkg::SUP_W-1:0]    nxt_sup_en;
    logic [afi_pkg::SYS_W-1:0]    sys_en_ff;
    logic [afi_pkg::SYS_W-1:0]    nxt_sys_en;
    logic [afi_pkg::BR_W-1:0]     br_en_ff;
    logic [afi_pkg::BR_W-1:0]     nxt_br_en;
    logic [afi_pkg::DW-1:0]       rdata_ff;
    logic [afi_pkg::DW-1:0]       nxt_rdata;
    logic                         err_ff;
    logic                         nxt_err;
    logic [afi_pkg::SUP_W-1:0]    sts_flags;
    logic [afi_pkg::SUP_W-1:0]    irq_flags;
    logic                         sup_req;
    logic                         sys_req;
    logic                         br_req;

    afi_flag_if #(.W(afi_pkg::SUP_W)) sts_if ();
    afi_flag_if #(.W(afi_pkg::SUP_W)) irq_if ();

    // Address decode; zero wait states
    assign apb_setup  = PSEL & ~PENABLE;
    assign apb_wr     = PSEL & PENABLE & PWRITE;
    assign hit_sts    = (PADDR == afi_pkg::OFS_SUP_STATUS);
    assign hit_sup_en = (PADDR == afi_pkg::OFS_SUP_EN);
    assign hit_clr    = (PADDR == afi_pkg::OFS_SUP_CLR);
    assign hit_sys    = (PADDR == afi_pkg::OFS_SYS_EN);
    assign hit_br     = (PADDR == afi_pkg::OFS_BR_EN);
    assign hit_any    = hit_sts | hit_sup_en | hit_clr | hit_sys | hit_br;
    assign PREADY     = 1'b1;
    assign PSLVERR    = PSEL & PENABLE & err_ff;

    // Supply flag banks: occurred status by level, interrupt by edge
    assign sts_if.det = {SUPPLY_OV_DET, SUPPLY_UV_DET};
    assign irq_if.det = {SUPPLY_OV_DET, SUPPLY_UV_DET};
    assign sts_if.clr = (apb_wr & hit_clr) ?
                        PWDATA[afi_pkg::STS_LSB +: afi_pkg::SUP_W] : '0;
    assign irq_if.clr = (apb_wr & hit_clr) ?
                        PWDATA[afi_pkg::IS_LSB +: afi_pkg::SUP_W] : '0;
    assign sts_flags  = sts_if.flags;
    assign irq_flags  = irq_if.flags;

    afi_flag_bank #(
        .W    (afi_pkg::SUP_W),
        .EDGE (1'b0)
    ) u_sts_bank (
        .clk (REF_CLK),
        .rst (SRST),
        .f   (sts_if.bank)
    );

    afi_flag_bank #(
        .W    (afi_pkg::SUP_W),
        .EDGE (1'b1)
    ) u_irq_bank (
        .clk (REF_CLK),
        .rst (SRST),
        .f   (irq_if.bank)
    );

    // Enable registers; reserved positions masked off on write
    always_comb begin
        nxt_sup_en = sup_en_ff;
        nxt_sys_en = sys_en_ff;
        if (apb_wr && hit_sup_en) begin
            nxt_sup_en = PWDATA[afi_pkg::SUP_W-1:0];
        end
        if (apb_wr && hit_sys) begin
            nxt_sys_en = PWDATA[afi_pkg::SYS_W-1:0] & afi_pkg::SYS_EN_MASK;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            sup_en_ff <= afi_pkg::SUP_EN_RST;
            sys_en_ff <= afi_pkg::SYS_EN_RST;
        end else begin
            sup_en_ff <= nxt_sup_en;
            sys_en_ff <= nxt_sys_en;
        end
    end

    // Bridge enables keep their value across the ordinary reset
    always_comb begin
        nxt_br_en = br_en_ff;
        if (apb_wr && hit_br && !SRST) begin
            nxt_br_en = PWDATA[afi_pkg::BR_W-1:0] & afi_pkg::BR_EN_MASK;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST3) begin
            br_en_ff <= afi_pkg::BR_EN_RST;
        end else begin
            br_en_ff <= nxt_br_en;
        end
    end

    // Read data captured in setup so it is stable through access
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_err   = err_ff;
        if (apb_setup) begin
            nxt_rdata = '0;
            nxt_err   = ~hit_any;
            if (hit_sts) begin
                nxt_rdata[afi_pkg::STS_LSB +: afi_pkg::SUP_W] = sts_flags;
                nxt_rdata[afi_pkg::IS_LSB +: afi_pkg::SUP_W]  = irq_flags;
            end
            if (hit_sup_en) begin
                nxt_rdata[afi_pkg::SUP_W-1:0] = sup_en_ff;
            end
            if (hit_sys) begin
                nxt_rdata[afi_pkg::SYS_W-1:0] = sys_en_ff;
            end
            if (hit_br) begin
                nxt_rdata[afi_pkg::BR_W-1:0] = br_en_ff;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            rdata_ff <= '0;
            err_ff   <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            err_ff   <= nxt_err;
        end
    end

    assign PRDATA = rdata_ff;

    // Level request; supply part dropped as soon as software clears its flag, system and bridge parts follow their inputs
    assign sup_req = |(irq_flags & sup_en_ff);
    assign sys_req = |(SYS_IRQ_FLAGS & sys_en_ff);
    assign br_req  = |(BRIDGE_IRQ_FLAGS & br_en_ff);
    assign IRQ     = sup_req | sys_req | br_req;

    // Checks
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);

    // Write-one clear of the battery interrupt bit
    sequence s_clr_bat_irq;
        apb_wr && hit_clr && PWDATA[afi_pkg::IS_LSB + afi_pkg::SUP_BAT];
    endsequence

    sequence s_bat_held;
        SUPPLY_UV_DET[afi_pkg::SUP_BAT] [*2];
    endsequence

    // Bridge write, then a read setup of the same register one or two cycles later
    sequence s_br_write;
        apb_wr && hit_br;
    endsequence

    sequence s_br_rd_setup;
        PSEL && !PENABLE && !PWRITE && hit_br;
    endsequence

    a_sts_clear: assert property (
        apb_wr && hit_clr && PWDATA[afi_pkg::STS_LSB + afi_pkg::SUP_BAT]
        && !SUPPLY_UV_DET[afi_pkg::SUP_BAT] |=> !sts_flags[afi_pkg::SUP_BAT])
        else $error("Status flag not cleared by write one");

    a_sts_zero_wr: assert property (
        apb_wr && hit_clr && (PWDATA[afi_pkg::STS_LSB +: afi_pkg::SUP_W] == '0)
        && sts_flags[afi_pkg::SUP_BAT] |=> sts_flags[afi_pkg::SUP_BAT])
        else $error("Status flag lost on write zero");

    a_irq_clear: assert property (
        s_clr_bat_irq and !SUPPLY_UV_DET[afi_pkg::SUP_BAT]
        |=> !irq_flags[afi_pkg::SUP_BAT])
        else $error("Interrupt flag not cleared by write one");

    a_ov_irq_set: assert property (
        $rose(SUPPLY_OV_DET[afi_pkg::SUP_CORE])
        |=> irq_flags[afi_pkg::OV_LSB + afi_pkg::SUP_CORE])
        else $error("Overvoltage interrupt flag not set");

    a_uv_irq_set: assert property (
        $rose(SUPPLY_UV_DET[afi_pkg::SUP_BAT])
        |=> irq_flags[afi_pkg::SUP_BAT])
        else $error("Undervoltage interrupt flag not set");

    a_edge_once: assert property (
        s_bat_held ##0 s_clr_bat_irq |=> !irq_flags[afi_pkg::SUP_BAT])
        else $error("Held detection raised second request");

    a_sys_write: assert property (
        apb_wr && hit_sys |=> sys_en_ff == ($past(PWDATA[afi_pkg::SYS_W-1:0])
        & afi_pkg::SYS_EN_MASK))
        else $error("System enable write not taken");

    a_sys_gate: assert property (
        SYS_IRQ_FLAGS[afi_pkg::SYS_OT_BIT] && sys_en_ff[afi_pkg::SYS_OT_BIT]
        |-> IRQ)
        else $error("Enabled system event gave no request");

    a_sys_rsvd: assert property (
        PSEL && PENABLE && hit_sys
        |-> PRDATA[afi_pkg::SYS_RSVD_MSB:afi_pkg::SYS_RSVD_LSB] == '0)
        else $error("System reserved bits read nonzero");

    a_br_reset: assert property (@(posedge REF_CLK) disable iff (RST3)
        SRST |=> $stable(br_en_ff))
        else $error("Bridge enable disturbed by ordinary reset");

    a_br_write: assert property (
        s_br_write ##[1:2] s_br_rd_setup
        |=> PRDATA[afi_pkg::BR_W-1:0] == br_en_ff)
        else $error("Bridge enable readback wrong");

    a_br_gate: assert property (
        BRIDGE_IRQ_FLAGS[afi_pkg::BR_HS2_OC_BIT]
        && br_en_ff[afi_pkg::BR_HS2_OC_BIT] |-> IRQ)
        else $error("Enabled overcurrent gave no request");

    a_br_take: assert property (
        apb_wr && hit_br && !RST3
        |=> br_en_ff == ($past(PWDATA[afi_pkg::BR_W-1:0]) & afi_pkg::BR_EN_MASK))
        else $error("Bridge enable write not taken");

    a_br_off: assert property (
        !br_en_ff[afi_pkg::BR_LS1_DS_BIT] && !sup_req && !sys_req
        && (BRIDGE_IRQ_FLAGS == afi_pkg::BR_W'(1)) |-> !IRQ)
        else $error("Disabled short event gave request");

    a_clr_reads0: assert property (
        PSEL && PENABLE && hit_clr |-> PRDATA == '0)
        else $error("Clear register read nonzero");

    a_br_rsvd: assert property (
        PSEL && PENABLE && hit_br
        |-> ((PRDATA[afi_pkg::BR_W-1:0] & ~afi_pkg::BR_EN_MASK) == '0)
        && (PRDATA[afi_pkg::DW-1:afi_pkg::BR_W] == '0))
        else $error("Bridge reserved bits read nonzero");

    a_sup_en_rst: assert property (
        $fell(SRST) |-> sup_en_ff == afi_pkg::SUP_EN_RST)
        else $error("Supply enable reset value wrong");

    a_sts_level: assert property (
        SUPPLY_OV_DET[afi_pkg::SUP_CORE]
        |=> sts_flags[afi_pkg::OV_LSB + afi_pkg::SUP_CORE] [*2])
        else $error("Overvoltage status not held");

    a_sup_gate: assert property (
        irq_flags[afi_pkg::OV_LSB] && sup_en_ff[afi_pkg::OV_LSB] |-> IRQ)
        else $error("Enabled supply flag gave no request");

    a_sup_en_wr: assert property (
        apb_wr && hit_sup_en |=> sup_en_ff == $past(PWDATA[afi_pkg::SUP_W-1:0]))
        else $error("Supply enable write not taken");

    // Clearing every pending supply bit with no new detection drops the request
    a_irq_drop: assert property (
        apb_wr && hit_clr && ((irq_flags & ~PWDATA[afi_pkg::IS_LSB +: afi_pkg::SUP_W]) == '0)
        && ({SUPPLY_OV_DET, SUPPLY_UV_DET} == '0) |=> !sup_req)
        else $error("Supply request kept after clear");

    a_irq_cause: assert property (
        IRQ |-> ((irq_flags & sup_en_ff) != '0) || ((SYS_IRQ_FLAGS & sys_en_ff) != '0)
        || ((BRIDGE_IRQ_FLAGS & br_en_ff) != '0))
        else $error("Request without enabled flag");
endmodule : afi_top
`default_nettype wire

// ### testbench/afi_meas_model.sv
// Measurement unit stand-in: supply detect levels and system/bridge flags.
// Assumes its tasks are called right after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module afi_meas_model (
    input  wire logic                      clk,
    output logic [afi_pkg::SUP_N-1:0]      ov_det,
    output logic [afi_pkg::SUP_N-1:0]      uv_det,
    output logic [afi_pkg::SYS_W-1:0]      sys_flags,
    output logic [afi_pkg::BR_W-1:0]       br_flags
);
    initial begin
        ov_det = '0;
        uv_det = '0;
        sys_flags = '0;
        br_flags = '0;
    end

    // One detection lasts a single cycle, then the line drops again
    task automatic pulse(input logic [7:0] v);
        {ov_det, uv_det} <= v;
        @(posedge clk);
        {ov_det, uv_det} <= 8'h00;
        @(posedge clk);
    endtask : pulse

    task automatic hold(input logic [7:0] v);
        {ov_det, uv_det} <= v;
        @(posedge clk);
    endtask : hold

    task automatic flags(input logic [15:0] s, input logic [20:0] b);
        sys_flags <= s;
        br_flags <= b;
        @(posedge clk);
    endtask : flags
endmodule : afi_meas_model
`default_nettype wire

// ### testbench/test_analog_fault_irq_regs.sv
// Self-checking bench for the analog fault interrupt registers.
// Assumes a single 25 MHz clock and a zero-wait APB slave.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_analog_fault_irq_regs;
    logic clk = 1'b0, srst = 1'b1, rst3 = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [afi_pkg::AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, irq;
    logic [3:0] ov, uv;
    logic [15:0] sysf;
    logic [20:0] brf;
    int fail_count = 0, compares = 0;

    afi_top afi_top_i (.REF_CLK(clk), .SRST(srst), .RST3(rst3), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SUPPLY_OV_DET(ov),
        .SUPPLY_UV_DET(uv), .SYS_IRQ_FLAGS(sysf), .BRIDGE_IRQ_FLAGS(brf), .IRQ(irq));
    afi_meas_model afi_meas_model_i (.clk(clk), .ov_det(ov), .uv_det(uv),
        .sys_flags(sysf), .br_flags(brf));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait states end only on pready; a hang is left to the watchdog
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle keeps two transfers from driving one signal twice
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(r, x)
        `CHK(e, xe)
    endtask : chk_rd

    task automatic irq_chk(input logic x);
        @(posedge clk);
        `CHK(irq, x)
    endtask : irq_chk

    task automatic t_reset_vals;
        chk_rd(afi_pkg::OFS_SUP_EN, 32'h000000FF, 1'b0);
        chk_rd(afi_pkg::OFS_SYS_EN, 32'h00000000, 1'b0);
        chk_rd(afi_pkg::OFS_BR_EN, 32'h00000000, 1'b0);
        chk_rd(afi_pkg::OFS_SUP_CLR, 32'h00000000, 1'b0);
        wr(afi_pkg::OFS_SUP_STATUS, 32'hFFFFFFFF);
        chk_rd(afi_pkg::OFS_SUP_STATUS, 32'h00000000, 1'b0);
        chk_rd(8'h40, 32'h00000000, 1'b1);
    endtask : t_reset_vals

    task automatic t_supply;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 8'h01 << i;
            afi_meas_model_i.pulse(v);
            chk_rd(afi_pkg::OFS_SUP_STATUS, {8'h00, v, 8'h00, v}, 1'b0);
            irq_chk(1'b1);
            wr(afi_pkg::OFS_SUP_CLR, 32'h0);
            chk_rd(afi_pkg::OFS_SUP_STATUS, {8'h00, v, 8'h00, v}, 1'b0);
            wr(afi_pkg::OFS_SUP_CLR, {24'h0, v});
            chk_rd(afi_pkg::OFS_SUP_STATUS, {8'h00, v, 16'h0}, 1'b0);
            irq_chk(1'b0);
            wr(afi_pkg::OFS_SUP_CLR, {8'h00, v, 16'h0});
            chk_rd(afi_pkg::OFS_SUP_STATUS, 32'h0, 1'b0);
        end
    endtask : t_supply

    task automatic t_edge_and_mask;
        afi_meas_model_i.hold(8'h81);
        repeat (3) @(posedge clk);
        wr(afi_pkg::OFS_SUP_CLR, 32'h00000081);
        // Level still high: occurred bits stay, interrupt bits must not return
        chk_rd(afi_pkg::OFS_SUP_STATUS, 32'h00810000, 1'b0);
        afi_meas_model_i.hold(8'h00);
        wr(afi_pkg::OFS_SUP_CLR, 32'h00810000);
        wr(afi_pkg::OFS_SUP_EN, 32'h0000007F);
        afi_meas_model_i.pulse(8'h80);
        irq_chk(1'b0);
        wr(afi_pkg::OFS_SUP_EN, 32'h00000080);
        irq_chk(1'b1);
        wr(afi_pkg::OFS_SUP_CLR, 32'h00800080);
        irq_chk(1'b0);
    endtask : t_edge_and_mask

    task automatic t_mask(input bit br);
        logic [31:0] one, m;
        logic [7:0] a;
        int n;
        a = br ? afi_pkg::OFS_BR_EN : afi_pkg::OFS_SYS_EN;
        n = br ? afi_pkg::BR_W : afi_pkg::SYS_W;
        m = br ? {11'h0, afi_pkg::BR_EN_MASK} : {16'h0, afi_pkg::SYS_EN_MASK};
        for (int i = 0; i < n; i++) begin
            one = 32'h1 << i;
            wr(a, one);
            chk_rd(a, one & m, 1'b0);
            afi_meas_model_i.flags(br ? 16'h0 : ~one[15:0], br ? ~one[20:0] : 21'h0);
            irq_chk(1'b0);
            afi_meas_model_i.flags(br ? 16'h0 : one[15:0], br ? one[20:0] : 21'h0);
            irq_chk(m[i]);
        end
        afi_meas_model_i.flags(16'h0, 21'h0);
    endtask : t_mask

    task automatic t_reset_class;
        wr(afi_pkg::OFS_BR_EN, 32'hFFFFFFFF);
        wr(afi_pkg::OFS_SUP_EN, 32'h0);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk_rd(afi_pkg::OFS_BR_EN, 32'h001F3C0F, 1'b0);
        chk_rd(afi_pkg::OFS_SUP_EN, 32'h000000FF, 1'b0);
        rst3 <= 1'b1;
        repeat (2) @(posedge clk);
        rst3 <= 1'b0;
        @(posedge clk);
        chk_rd(afi_pkg::OFS_BR_EN, 32'h00000000, 1'b0);
    endtask : t_reset_class

    task automatic end_of_test;
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rst3 <= 1'b0;
        @(posedge clk);
        t_reset_vals();
        t_supply();
        t_edge_and_mask();
        t_mask(1'b0);
        t_mask(1'b1);
        t_reset_class();
        end_of_test();
    end

    // About 650 cycles expected; cut a hang well after that
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
endmodule : test_analog_fault_irq_regs
`default_nettype wire
